/* include/ccirb_defs.vh */
// Purpose: offsets, reset values and timing counts of the common config bank
// Assumes: byte-wide host bus, big-endian multi-byte registers
// Notes: definitions only
`ifndef CCIRB_DEFS_VH
`define CCIRB_DEFS_VH

`define CCIRB_OFS_CAUSE 8'h15
`define CCIRB_OFS_ENABLE 8'h16
`define CCIRB_OFS_PERIOD_HI 8'h17
`define CCIRB_OFS_PERIOD_LO 8'h18
`define CCIRB_OFS_LIMIT 8'h19
`define CCIRB_OFS_RXSIZE 8'h1a
`define CCIRB_OFS_TXSIZE 8'h1b
`define CCIRB_OFS_AUTH_HI 8'h1c
`define CCIRB_OFS_AUTH_LO 8'h1d
`define CCIRB_OFS_ECHO 8'h28
`define CCIRB_OFS_MAGIC 8'h29
`define CCIRB_OFS_ADDR0 8'h2a
`define CCIRB_OFS_ADDR1 8'h2b
`define CCIRB_OFS_ADDR2 8'h2c
`define CCIRB_OFS_ADDR3 8'h2d
`define CCIRB_OFS_PORT_HI 8'h2e
`define CCIRB_OFS_PORT_LO 8'h2f

`define CCIRB_RST_ENABLE 8'h00
`define CCIRB_RST_PERIOD 16'h07d0
`define CCIRB_RST_LIMIT 8'h08
`define CCIRB_RST_SIZES 8'h55
`define CCIRB_RST_AUTH 16'h0000
`define CCIRB_RST_ECHO 8'h28
`define CCIRB_RST_MAGIC 8'h00

`define CCIRB_AUTH_PAP 16'hc023
`define CCIRB_AUTH_CHAP 16'hc223

`define CCIRB_BIT_CLASH 7
`define CCIRB_BIT_NOROUTE 6
`define CCIRB_BIT_LINKCLOSE 5
`define CCIRB_BIT_RESERVED 4
`define CCIRB_ENABLE_WMASK 8'hef

`define CCIRB_CLK_HZ 25000000
`define CCIRB_TICK_US 100
`define CCIRB_TICK_CYCLES ((`CCIRB_CLK_HZ / 1000000) * `CCIRB_TICK_US)
`define CCIRB_BUF_TOTAL_KB 8

`endif

/* src/ccirb_buf_alloc.v */
// Purpose: turn four 2-bit size codes into per-socket buffer bases and sizes
// Assumes: codes 0..3 mean 1, 2, 4, 8 KB; space handed out from socket 0 up
// Notes: a socket that does not fit gets size zero and its unusable flag
`timescale 1ns/1ns
`include "ccirb_defs.vh"
module ccirb_buf_alloc #(
    parameter TOTAL_KB = `CCIRB_BUF_TOTAL_KB
)(
    // size codes
    input wire [7:0] size_codes,
    // allocation
    output wire [19:0] base_kb,
    output wire [19:0] size_kb,
    output wire [3:0] unusable
);
    wire [5:0] run [0:4];
    assign run[0] = 6'h00;
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_sock
            wire [4:0] want;
            wire fits;
            assign want = 5'h01 << size_codes[2*i+1:2*i];
            assign fits = ({1'b0, run[i]} + {2'b00, want}) <= TOTAL_KB;
            assign run[i+1] = fits ? run[i] + {1'b0, want} : run[i];
            assign base_kb[5*i+4:5*i] = run[i][4:0];
            assign size_kb[5*i+4:5*i] = fits ? want : 5'h00;
            assign unusable[i] = ~fits;
        end
    endgenerate
endmodule // ccirb_buf_alloc

/* src/ccirb_retry_timer.v */
// Purpose: per-socket retransmission deadline and retry counting
// Assumes: engine pulses start on a command needing an answer, ack on answer
// Notes: one shared 100 us tick derived from clk
`timescale 1ns/1ns
`include "ccirb_defs.vh"
module ccirb_retry_timer #(
    parameter TICK_CYCLES = `CCIRB_TICK_CYCLES
)(
    // clock and reset
    input wire clk,
    input wire nrst,
    // settings
    input wire [15:0] period,
    input wire [7:0] limit,
    // engine side, one bit per socket
    input wire [3:0] start,
    input wire [3:0] ack,
    output wire [3:0] resend,
    output wire [3:0] timeout
);
    reg [15:0] pre_q;
    wire tick;
    assign tick = (pre_q == TICK_CYCLES - 1);
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pre_q <= 16'h0000;
        else if (tick)
            pre_q <= 16'h0000;
        else
            pre_q <= pre_q + 16'h0001;
    end
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_sock
            reg busy_q;
            reg [15:0] cnt_q;
            reg [8:0] tries_q;
            reg resend_q;
            reg timeout_q;
            wire expire;
            assign expire = busy_q && tick && (cnt_q + 16'h0001 >= period);
            always @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    busy_q <= 1'b0;
                    cnt_q <= 16'h0000;
                    tries_q <= 9'h000;
                    resend_q <= 1'b0;
                    timeout_q <= 1'b0;
                end
                else
                begin
                    resend_q <= 1'b0;
                    timeout_q <= 1'b0;
                    if (start[i])
                    begin
                        busy_q <= 1'b1;
                        cnt_q <= 16'h0000;
                        tries_q <= 9'h000;
                    end
                    else if (ack[i])
                        busy_q <= 1'b0;
                    else if (expire)
                    begin
                        cnt_q <= 16'h0000;
                        if (tries_q >= {1'b0, limit})
                        begin
                            busy_q <= 1'b0;
                            timeout_q <= 1'b1;
                        end
                        else
                        begin
                            tries_q <= tries_q + 9'h001;
                            resend_q <= 1'b1;
                        end
                    end
                    else if (busy_q && tick)
                        cnt_q <= cnt_q + 16'h0001;
                end
            end
            assign resend[i] = resend_q;
            assign timeout[i] = timeout_q;
        end
    endgenerate
endmodule // ccirb_retry_timer

/* src/ccirb_regs.v */
// Purpose: common config bank: event enable, retry, buffer sizes, link, no-route capture
// Assumes: byte host bus synchronous to clk; engine strobes on clk
// Notes: multi-byte registers are big-endian
// How it works
// - interrupt asserted when a cause bit and its enable bit are both set
// - enable bits: 7 clash, 6 no-route, 5 link close, 3..0 sockets; 4 reserved
// - retry period is 16 bits in 100 us units, resets to 2000
// - unanswered commands are resent after the retry period
// - retry limit resets to 8; exceeding it raises socket timeout flag
// - rx sizes: four 2-bit fields, socket 0 in lowest bits
// - size codes 00..11 select 1, 2, 4, 8 KB
// - space handed out from socket 0 within 8 KB; unfit sockets unusable
// - rx sizes reset to 0x55, 2 KB each
// - tx sizes same layout and allocation, reset 0x55
// - auth kind is read-only, PAP c023 or CHAP c223, resets zero
// - echo interval in about 25 ms units, resets to 0x28
// - negotiation magic value, resets to zero
// - no-route event captures address and port
// - multi-byte registers keep most significant byte at lowest address
// - interrupt stays low while any enabled cause remains set
// - clash, no-route and link close clear on write of one
// - socket cause bits clear when socket flags read zero
`timescale 1ns/1ns
`include "ccirb_defs.vh"
module ccirb_regs #(
    parameter TICK_CYCLES = `CCIRB_TICK_CYCLES,
    parameter TOTAL_KB = `CCIRB_BUF_TOTAL_KB
)(
    // clock and reset
    input wire clk,
    input wire nrst,
    // host bus
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    // interrupt pin
    output reg int_n,
    // engine events
    input wire clash_evt,
    input wire link_close_evt,
    input wire no_route_evt,
    input wire [31:0] no_route_addr_in,
    input wire [15:0] no_route_port_in,
    input wire auth_valid,
    input wire [15:0] auth_kind_in,
    input wire [3:0] socket_event_flags_nz,
    input wire [3:0] retry_start,
    input wire [3:0] retry_ack,
    // engine settings and results
    output reg [15:0] retry_period,
    output reg [7:0] echo_interval,
    output reg [7:0] negotiation_magic,
    output reg [19:0] rx_base_kb,
    output reg [19:0] rx_size_kb,
    output reg [3:0] rx_unusable,
    output reg [19:0] tx_base_kb,
    output reg [19:0] tx_size_kb,
    output reg [3:0] tx_unusable,
    output reg [3:0] retry_resend,
    output reg [3:0] retry_timeout
);
    reg [7:0] event_enable_q;
    reg [15:0] retry_period_q;
    reg [7:0] retry_limit_q;
    reg [7:0] rx_buffer_sizes_q;
    reg [7:0] tx_buffer_sizes_q;
    reg [15:0] link_auth_kind_q;
    reg [7:0] echo_interval_q;
    reg [7:0] negotiation_magic_q;
    reg [31:0] no_route_address_q;
    reg [15:0] no_route_port_number_q;
    reg [7:0] event_cause_flags_q;
    reg [7:0] rdata_d;
    wire [19:0] rx_base_w;
    wire [19:0] rx_size_w;
    wire [3:0] rx_unusable_w;
    wire [19:0] tx_base_w;
    wire [19:0] tx_size_w;
    wire [3:0] tx_unusable_w;
    wire [3:0] resend_w;
    wire [3:0] timeout_w;
    wire wr_cause;
    wire [7:0] cause_d;

    // write-one-to-clear for the three global causes, set wins over clear
    assign wr_cause = wr && (addr == `CCIRB_OFS_CAUSE);
    assign cause_d[`CCIRB_BIT_CLASH] = clash_evt ||
        (event_cause_flags_q[`CCIRB_BIT_CLASH] && !(wr_cause && wdata[`CCIRB_BIT_CLASH]));
    assign cause_d[`CCIRB_BIT_NOROUTE] = no_route_evt ||
        (event_cause_flags_q[`CCIRB_BIT_NOROUTE] &&
        !(wr_cause && wdata[`CCIRB_BIT_NOROUTE]));
    assign cause_d[`CCIRB_BIT_LINKCLOSE] = link_close_evt ||
        (event_cause_flags_q[`CCIRB_BIT_LINKCLOSE] &&
        !(wr_cause && wdata[`CCIRB_BIT_LINKCLOSE]));
    assign cause_d[`CCIRB_BIT_RESERVED] = 1'b0;
    assign cause_d[3:0] = socket_event_flags_nz;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            event_enable_q <= `CCIRB_RST_ENABLE;
            retry_period_q <= `CCIRB_RST_PERIOD;
            retry_limit_q <= `CCIRB_RST_LIMIT;
            rx_buffer_sizes_q <= `CCIRB_RST_SIZES;
            tx_buffer_sizes_q <= `CCIRB_RST_SIZES;
            link_auth_kind_q <= `CCIRB_RST_AUTH;
            echo_interval_q <= `CCIRB_RST_ECHO;
            negotiation_magic_q <= `CCIRB_RST_MAGIC;
            no_route_address_q <= 32'h00000000;
            no_route_port_number_q <= 16'h0000;
            event_cause_flags_q <= 8'h00;
        end
        else
        begin
            event_cause_flags_q <= cause_d;
            if (auth_valid)
                link_auth_kind_q <= auth_kind_in;
            if (no_route_evt)
            begin
                no_route_address_q <= no_route_addr_in;
                no_route_port_number_q <= no_route_port_in;
            end
            if (wr)
            begin
                case (addr)
                    `CCIRB_OFS_ENABLE: event_enable_q <= wdata & `CCIRB_ENABLE_WMASK;
                    `CCIRB_OFS_PERIOD_HI: retry_period_q[15:8] <= wdata;
                    `CCIRB_OFS_PERIOD_LO: retry_period_q[7:0] <= wdata;
                    `CCIRB_OFS_LIMIT: retry_limit_q <= wdata;
                    `CCIRB_OFS_RXSIZE: rx_buffer_sizes_q <= wdata;
                    `CCIRB_OFS_TXSIZE: tx_buffer_sizes_q <= wdata;
                    `CCIRB_OFS_ECHO: echo_interval_q <= wdata;
                    `CCIRB_OFS_MAGIC: negotiation_magic_q <= wdata;
                    default: ;
                endcase
            end
        end
    end

    // big-endian read mux
    always @*
    begin
        case (addr)
            `CCIRB_OFS_CAUSE: rdata_d = event_cause_flags_q;
            `CCIRB_OFS_ENABLE: rdata_d = event_enable_q;
            `CCIRB_OFS_PERIOD_HI: rdata_d = retry_period_q[15:8];
            `CCIRB_OFS_PERIOD_LO: rdata_d = retry_period_q[7:0];
            `CCIRB_OFS_LIMIT: rdata_d = retry_limit_q;
            `CCIRB_OFS_RXSIZE: rdata_d = rx_buffer_sizes_q;
            `CCIRB_OFS_TXSIZE: rdata_d = tx_buffer_sizes_q;
            `CCIRB_OFS_AUTH_HI: rdata_d = link_auth_kind_q[15:8];
            `CCIRB_OFS_AUTH_LO: rdata_d = link_auth_kind_q[7:0];
            `CCIRB_OFS_ECHO: rdata_d = echo_interval_q;
            `CCIRB_OFS_MAGIC: rdata_d = negotiation_magic_q;
            `CCIRB_OFS_ADDR0: rdata_d = no_route_address_q[31:24];
            `CCIRB_OFS_ADDR1: rdata_d = no_route_address_q[23:16];
            `CCIRB_OFS_ADDR2: rdata_d = no_route_address_q[15:8];
            `CCIRB_OFS_ADDR3: rdata_d = no_route_address_q[7:0];
            `CCIRB_OFS_PORT_HI: rdata_d = no_route_port_number_q[15:8];
            `CCIRB_OFS_PORT_LO: rdata_d = no_route_port_number_q[7:0];
            default: rdata_d = 8'h00;
        endcase
    end

    ccirb_buf_alloc #(
        .TOTAL_KB(TOTAL_KB)
    ) u_rx_alloc (
        .size_codes(rx_buffer_sizes_q),
        .base_kb(rx_base_w),
        .size_kb(rx_size_w),
        .unusable(rx_unusable_w)
    );

    ccirb_buf_alloc #(
        .TOTAL_KB(TOTAL_KB)
    ) u_tx_alloc (
        .size_codes(tx_buffer_sizes_q),
        .base_kb(tx_base_w),
        .size_kb(tx_size_w),
        .unusable(tx_unusable_w)
    );

    ccirb_retry_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_retry (
        .clk(clk),
        .nrst(nrst),
        .period(retry_period_q),
        .limit(retry_limit_q),
        .start(retry_start),
        .ack(retry_ack),
        .resend(resend_w),
        .timeout(timeout_w)
    );

    // registered outputs
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
            int_n <= 1'b1;
            retry_period <= `CCIRB_RST_PERIOD;
            echo_interval <= `CCIRB_RST_ECHO;
            negotiation_magic <= `CCIRB_RST_MAGIC;
            rx_base_kb <= 20'h00000;
            rx_size_kb <= 20'h00000;
            rx_unusable <= 4'h0;
            tx_base_kb <= 20'h00000;
            tx_size_kb <= 20'h00000;
            tx_unusable <= 4'h0;
            retry_resend <= 4'h0;
            retry_timeout <= 4'h0;
        end
        else
        begin
            if (rd)
                rdata <= rdata_d;
            int_n <= ~|(event_cause_flags_q & event_enable_q);
            retry_period <= retry_period_q;
            echo_interval <= echo_interval_q;
            negotiation_magic <= negotiation_magic_q;
            rx_base_kb <= rx_base_w;
            rx_size_kb <= rx_size_w;
            rx_unusable <= rx_unusable_w;
            tx_base_kb <= tx_base_w;
            tx_size_kb <= tx_size_w;
            tx_unusable <= tx_unusable_w;
            retry_resend <= resend_w;
            retry_timeout <= timeout_w;
        end
    end
endmodule // ccirb_regs

/* bench/ccirb_regs_properties.sv */
// Purpose: port-level checks of the common config bank
// Assumes: one clock, async active-low reset
// Notes: a small shadow of enable and cause bits feeds the interrupt checks
`timescale 1ns/1ns
module ccirb_regs_properties #(
    parameter TICK_CYCLES = 4,
    parameter TOTAL_KB = 8
)(
    // clock and reset
    input wire clk,
    input wire nrst,
    // host bus
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    input wire [7:0] rdata,
    input wire int_n,
    // engine side
    input wire clash_evt,
    input wire link_close_evt,
    input wire no_route_evt,
    input wire [3:0] socket_event_flags_nz,
    input wire [3:0] retry_start,
    input wire [3:0] retry_ack,
    input wire [15:0] retry_period,
    input wire [7:0] echo_interval,
    input wire [7:0] negotiation_magic,
    input wire [3:0] retry_resend,
    input wire [3:0] retry_timeout
);
    reg [7:0] en_q;
    reg [7:0] cause_q;
    reg [3:0] fl_q;
    reg [3:0] fl_qq;
    reg irq_q;
    wire fl_still = (socket_event_flags_nz == fl_q) && (fl_q == fl_qq);
    wire [2:0] clr = (wr && addr == 8'h15) ? wdata[7:5] : 3'h0;
    // shadow of the enable and cause registers
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_q <= 8'h00;
            cause_q <= 8'h00;
            fl_q <= 4'h0;
            fl_qq <= 4'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            en_q <= (wr && addr == 8'h16) ? (wdata & 8'hef) : en_q;
            cause_q <= {{clash_evt, no_route_evt, link_close_evt} | (cause_q[7:5] & ~clr),
                1'b0, socket_event_flags_nz};
            fl_q <= socket_event_flags_nz;
            fl_qq <= fl_q;
            irq_q <= |(cause_q & en_q);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_hi_wr;
        wr && addr == 8'h17;
    endsequence
    sequence s_ack_idle;
        retry_ack[1] ##1 !retry_start[1] [*4];
    endsequence
    chk_int_level: assert property (fl_still |-> int_n == !irq_q)
        else $error("interrupt pin disagrees with enabled causes");
    chk_enable_read: assert property (rd && addr == 8'h16 |=> rdata == $past(en_q))
        else $error("enable read wrong");
    chk_cause_read: assert property (rd && addr == 8'h15 && fl_still |=> rdata == $past(cause_q))
        else $error("cause read wrong");
    chk_period_copy: assert property (s_hi_wr |=> ##1 retry_period[15:8] == $past(wdata, 2))
        else $error("period upper byte not applied");
    chk_echo_copy: assert property (wr && addr == 8'h28 |=> ##1 echo_interval == $past(wdata, 2))
        else $error("echo interval not applied");
    chk_magic_copy: assert property (wr && addr == 8'h29 |=> ##1 negotiation_magic == $past(wdata, 2))
        else $error("magic value not applied");
    chk_resend_pulse: assert property (retry_resend[0] |=> !retry_resend[0])
        else $error("resend longer than one cycle");
    chk_timeout_end: assert property (retry_timeout[0] |=> !retry_timeout[0] && !retry_resend[0])
        else $error("socket still active after timeout");
    chk_ack_quiet: assert property (s_ack_idle |=> !retry_resend[1])
        else $error("resend after answer");
endmodule // ccirb_regs_properties

bind ccirb_regs ccirb_regs_properties #(.TICK_CYCLES(TICK_CYCLES), .TOTAL_KB(TOTAL_KB)) u_props (
    .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .int_n, .clash_evt, .link_close_evt,
    .no_route_evt, .socket_event_flags_nz, .retry_start, .retry_ack, .retry_period,
    .echo_interval, .negotiation_magic, .retry_resend, .retry_timeout);

/* bench/ccirb_host.sv */
// Purpose: host processor model on the byte register bus
// Assumes: one strobe cycle per access, signals change at falling edge
// Notes: read data taken one cycle after the read strobe
`timescale 1ns/1ns
module ccirb_host (
    // clock
    input wire clk,
    // bus
    output reg [7:0] addr,
    output reg [7:0] wdata,
    output reg wr,
    output reg rd,
    // read data
    input wire [7:0] rdata
);
    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    task put(input [7:0] a, input [7:0] d);
    begin
        @(negedge clk);
        addr = a;
        wdata = (a == 8'h16) ? (d & 8'hef) : d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    end
    endtask
    task get(input [7:0] a, output [7:0] d);
    begin
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    end
    endtask
endmodule // ccirb_host

/* bench/ccirb_regs_bench.sv */
// Purpose: self-checking bench of the common config bank
// Assumes: retry tick shortened to 4 cycles
// Notes: integer register image predicts every read and every output except retry_resend and retry_timeout
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ccirb_regs_bench;
    reg clk, nrst, ce, le, ne, av;
    reg [31:0] na;
    reg [15:0] np, ak;
    reg [3:0] sf, rs, ra;
    reg [7:0] v;
    wire [7:0] addr, wdata, rdata, echo, mag;
    wire wr, rd, int_n;
    wire [15:0] per;
    wire [19:0] rxb, rxs, txb, txs;
    wire [3:0] rxu, txu, rsd, tmo;
    integer err_count, check_count, i, j, k, n, m, t0, t1;
    integer cyc = 0;
    integer mdl [0:255];
    ccirb_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    ccirb_regs #(.TICK_CYCLES(4), .TOTAL_KB(8)) uut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .int_n(int_n), .clash_evt(ce),
        .link_close_evt(le), .no_route_evt(ne), .no_route_addr_in(na), .no_route_port_in(np),
        .auth_valid(av), .auth_kind_in(ak), .socket_event_flags_nz(sf), .retry_start(rs),
        .retry_ack(ra), .retry_period(per), .echo_interval(echo), .negotiation_magic(mag),
        .rx_base_kb(rxb), .rx_size_kb(rxs), .rx_unusable(rxu), .tx_base_kb(txb),
        .tx_size_kb(txs), .tx_unusable(txu), .retry_resend(rsd), .retry_timeout(tmo));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_sim;
        end
    end
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task chk_alloc(input [7:0] c, input [19:0] b, input [19:0] s, input [3:0] u);
        integer used, sz, x;
    begin
        used = 0;
        for (x = 0; x < 4; x++)
        begin
            sz = 1 << c[2*x +: 2];
            if (used + sz <= 8)
            begin
                `CHK(s[5*x +: 5], sz[4:0])
                `CHK(b[5*x +: 5], used[4:0])
                `CHK(u[x], 1'b0)
                used = used + sz;
            end
            else
            begin
                `CHK(s[5*x +: 5], 5'h00)
                `CHK(u[x], 1'b1)
            end
        end
    end
    endtask
    // read every register and compare outputs with the image
    task sweep;
        integer a;
    begin
        for (a = 8'h15; a <= 8'h30; a++)
        begin
            host.get(a[7:0], v);
            `CHK(v, mdl[a][7:0])
        end
        `CHK(per, {mdl[8'h17][7:0], mdl[8'h18][7:0]})
        `CHK(echo, mdl[8'h28][7:0])
        `CHK(mag, mdl[8'h29][7:0])
        chk_alloc(mdl[8'h1a][7:0], rxb, rxs, rxu);
        chk_alloc(mdl[8'h1b][7:0], txb, txs, txu);
    end
    endtask
    initial
    begin
        err_count = 0;
        check_count = 0;
        nrst = 1'b0;
        {ce, le, ne, av, na, np, ak, sf, rs, ra} = 0;
        for (i = 0; i < 256; i++)
            mdl[i] = 0;
        mdl[8'h17] = 8'h07;
        mdl[8'h18] = 8'hd0;
        mdl[8'h19] = 8'h08;
        mdl[8'h1a] = 8'h55;
        mdl[8'h1b] = 8'h55;
        mdl[8'h28] = 8'h28;
        v = 8'($urandom(32'hb44b15b5));
        repeat (16) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        sweep;
        $display("test reset values done");
        for (j = 0; j < 4; j++)
        begin
            for (i = 8'h16; i <= 8'h30; i++)
            begin
                v = (j == 0 && i == 8'h1a) ? 8'haa : 8'($urandom);
                host.put(i[7:0], v);
                if (i == 8'h16)
                    mdl[i] = v & 8'hef;
                else if ((i >= 8'h17 && i <= 8'h1b) || i == 8'h28 || i == 8'h29)
                    mdl[i] = v;
            end
            repeat (2) @(negedge clk);
            sweep;
        end
        $display("test register access done");
        for (j = 0; j < 8; j++)
        begin
            v = 8'($urandom);
            host.put(8'h16, v);
            mdl[8'h16] = v & 8'hef;
            k = $urandom;
            na = $urandom;
            np = 16'($urandom);
            @(negedge clk);
            {ce, ne, le} = k[2:0];
            sf = k[7:4];
            @(negedge clk);
            {ce, ne, le} = 3'h0;
            mdl[8'h15] = (mdl[8'h15] & 8'he0) | {k[2:0], 1'b0, k[7:4]};
            if (k[1])
                {mdl[8'h2a], mdl[8'h2b], mdl[8'h2c], mdl[8'h2d], mdl[8'h2e], mdl[8'h2f]}
                    = {24'h0, na[31:24], 24'h0, na[23:16], 24'h0, na[15:8],
                       24'h0, na[7:0], 24'h0, np[15:8], 24'h0, np[7:0]};
            repeat (3) @(negedge clk);
            `CHK(int_n, !(|(mdl[8'h15] & mdl[8'h16])))
            sweep;
            v = 8'($urandom);
            host.put(8'h15, v);
            mdl[8'h15] = mdl[8'h15] & ~(v & 8'he0);
            repeat (3) @(negedge clk);
            `CHK(int_n, !(|(mdl[8'h15] & mdl[8'h16])))
        end
        sf = 4'h0;
        host.put(8'h15, 8'he0);
        mdl[8'h15] = 0;
        repeat (3) @(negedge clk);
        `CHK(int_n, 1'b1)
        for (i = 0; i < 2; i++)
        begin
            @(negedge clk);
            ak = i ? 16'hc223 : 16'hc023;
            av = 1'b1;
            @(negedge clk);
            av = 1'b0;
            mdl[8'h1c] = ak[15:8];
            mdl[8'h1d] = ak[7:0];
            sweep;
        end
        $display("test events done");
        host.put(8'h17, 8'h00);
        host.put(8'h18, 8'h02);
        host.put(8'h19, 8'h02);
        @(negedge clk) rs = 4'h3;
        @(negedge clk) rs = 4'h0;
        @(negedge clk) ra = 4'h2;
        @(negedge clk) ra = 4'h0;
        {n, m, t0, t1} = 0;
        for (i = 0; i < 400 && tmo[0] !== 1'b1; i++)
        begin
            @(negedge clk);
            if (rsd[0] === 1'b1)
            begin
                n++;
                t0 = t1;
                t1 = cyc;
            end
            m = m + (rsd[1] | tmo[1]);
        end
        `CHK(tmo[0], 1'b1)
        `CHK(n, 2)
        `CHK(t1 - t0, 8)
        `CHK(m, 0)
        $display("test retry done");
        end_sim;
    end
endmodule // ccirb_regs_bench
